// >>> shared/spi_cmd_pkg.sv
// constants for the spi command decoder and response formatter
// assumes 32-bit frames, msb first, one frame per chip-select assertion
package spi_cmd_pkg;
  localparam int FRAME_BITS = 32;
  localparam logic [3:0] OP_RD_CMD = 4'hc;
  localparam logic [3:0] OP_WR_CMD = 4'h8;
  localparam logic [3:0] OP_RD_RESP = 4'h6;
  localparam logic [3:0] OP_WR_RESP = 4'h4;
  localparam logic [1:0] HEALTH_ERR = 2'h3;
  localparam logic [7:0] CRC_POLY = 8'h2f;
  localparam logic [7:0] CRC_SEED = 8'hff;
  localparam logic [7:0] LOCK_RESET_ADDR = 8'h0e;
  localparam int RESET_FIELD_LSB = 0;
  localparam logic [7:0] RESET_FIELD_MASK = 8'h03;
  localparam int OP_MSB = 31;
  localparam int OP_LSB = 28;
  localparam int ADDR_MSB = 23;
  localparam int ADDR_LSB = 16;
  localparam int DATA_MSB = 15;
  localparam int DATA_LSB = 8;
  localparam logic [4:0] BIT_CNT_LAST = 5'h1f;

  // one serial crc step, msb first
  function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic din);
    logic fb;
    fb = crc[7] ^ din;
    crc_step = {crc[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
  endfunction : crc_step
endpackage : spi_cmd_pkg

// >>> hdl/link_sync.sv
// three-stage synchroniser with agreement check for one pin
// assumes the pin is asynchronous to ref_clk_i
`timescale 1ns/1ps
module link_sync (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // pin and result
  input wire logic pin_i,
  input wire logic init_i,
  output logic level_o
);
  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic level_reg;
  logic level_next;

  // stage 1 feeds stage 2 only; stages 2 and 3 must agree
  // stages hold the pin relative to its idle level, so reset needs only constants
  always_comb begin
    sync_next = {sync_reg[1:0], pin_i ^ init_i};
    level_next = level_reg;
    if (sync_reg[1] == sync_reg[2]) begin
      level_next = sync_reg[2];
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_reg <= 3'h0;
      level_reg <= 1'b0;
    end else begin
      sync_reg <= sync_next;
      level_reg <= level_next;
    end
  end

  // back to pin polarity; no false edge after reset
  assign level_o = level_reg ^ init_i;
endmodule : link_sync

// >>> hdl/spi_cmd_core.sv
// spi command decoder, register file and response formatter
// assumes an spi host in mode 0 (sample on rising sclk, shift on falling)
`timescale 1ns/1ps
module spi_cmd_core
  import spi_cmd_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // spi pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_n_o,
  // status and sample sources
  input wire logic [1:0] basic_health_bits_i,
  input wire logic [1:0] detail_fault_bits_i,
  input wire logic miso_verify_err_i,
  input wire logic [95:0] measurement_value_i,
  input wire logic [255:0] read_only_map_i,
  // register and event outputs
  output logic config_lock_bit_o,
  output logic [1:0] reset_request_o,
  output logic write_done_o,
  output logic crc_error_o
);
  logic sclk_s, cs_n_s, mosi_s;
  link_sync u_sclk (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .pin_i(sclk_i), .init_i(1'b0), .level_o(sclk_s));
  link_sync u_cs (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .pin_i(cs_n_i), .init_i(1'b1), .level_o(cs_n_s));
  link_sync u_mosi (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .pin_i(mosi_i), .init_i(1'b0), .level_o(mosi_s));

  typedef enum logic [1:0] {
    RESP_READ = 2'b00,
    RESP_WRITE = 2'b01,
    RESP_SAMPLE = 2'b10,
    RESP_ERROR = 2'b11
  } resp_kind_e;

  logic [7:0] regs_reg [0:255];
  logic [7:0] regs_next [0:255];
  logic sclk_d_reg, sclk_d_next, cs_d_reg, cs_d_next;
  logic [31:0] rx_reg, rx_next, tx_reg, tx_next;
  logic [5:0] nbits_reg, nbits_next;
  logic [7:0] crc_reg, crc_next;
  resp_kind_e kind_reg, kind_next;
  logic [2:0] chan_reg, chan_next;
  logic [15:0] rdata_reg, rdata_next;
  logic miso_reg, miso_next, oe_n_reg, oe_n_next, done_reg, done_next, crcerr_reg, crcerr_next;

  wire sclk_rise = sclk_s && !sclk_d_reg;
  wire sclk_fall = !sclk_s && sclk_d_reg;
  wire cs_fall = !cs_n_s && cs_d_reg;
  wire cs_rise = cs_n_s && !cs_d_reg;

  // crc over a 24-bit header, returned as the trailing byte
  function automatic logic [7:0] crc_of(input logic [23:0] hdr);
    logic [7:0] c;
    c = CRC_SEED;
    for (int i = 23; i >= 0; i--) begin
      c = crc_step(c, hdr[i]);
    end
    crc_of = c;
  endfunction : crc_of

  // sample source by channel code, 12 bits each
  function automatic logic [11:0] pick_sample(input logic [95:0] src, input logic [2:0] ch);
    pick_sample = src[ch*12 +: 12];
  endfunction : pick_sample

  // frame engine: receive, check, execute at frame end, load answer at frame start
  always_comb begin
    logic [3:0] op;
    logic [7:0] addr;
    logic [7:0] data;
    logic crc_ok, locked, allowed;
    logic [23:0] hdr;
    op = rx_reg[OP_MSB:OP_LSB];
    addr = rx_reg[ADDR_MSB:ADDR_LSB];
    data = rx_reg[DATA_MSB:DATA_LSB];
    crc_ok = (crc_reg == 8'h00);
    locked = config_lock_bit_o;
    allowed = 1'b0;
    hdr = 24'h000000;
    for (int i = 0; i < 256; i++) begin
      regs_next[i] = regs_reg[i];
    end
    sclk_d_next = sclk_s;
    cs_d_next = cs_n_s;
    rx_next = rx_reg;
    tx_next = tx_reg;
    nbits_next = nbits_reg;
    crc_next = crc_reg;
    kind_next = kind_reg;
    chan_next = chan_reg;
    rdata_next = rdata_reg;
    miso_next = miso_reg;
    oe_n_next = cs_n_s;
    done_next = 1'b0;
    crcerr_next = 1'b0;
    if (cs_fall) begin
      // build the answer to the previous command
      nbits_next = 6'h00;
      crc_next = CRC_SEED;
      case (kind_reg)
        RESP_READ: hdr = {OP_RD_RESP, basic_health_bits_i, 2'b00, rdata_reg};
        RESP_WRITE: hdr = {OP_WR_RESP, basic_health_bits_i, 2'b00, rdata_reg};
        RESP_SAMPLE: hdr = {chan_reg, 1'b1, basic_health_bits_i, pick_sample(measurement_value_i, chan_reg),
                            4'h0, detail_fault_bits_i};
        default: hdr = {4'h0, HEALTH_ERR, 16'h0000, detail_fault_bits_i};
      endcase
      tx_next = {hdr, crc_of(hdr)};
      miso_next = hdr[23];
    end else if (!cs_n_s && sclk_rise) begin
      rx_next = {rx_reg[30:0], mosi_s};
      crc_next = crc_step(crc_reg, mosi_s);
      nbits_next = (nbits_reg == 6'(FRAME_BITS)) ? nbits_reg : nbits_reg + 6'h01;
    end else if (!cs_n_s && sclk_fall) begin
      tx_next = {tx_reg[30:0], 1'b0};
      miso_next = tx_reg[30];
    end else if (cs_rise) begin
      // execute only once the whole frame has arrived
      kind_next = RESP_ERROR;
      if (nbits_reg != 6'(FRAME_BITS) || !crc_ok || miso_verify_err_i) begin
        crcerr_next = !crc_ok;
      end else if (op == OP_RD_CMD) begin
        kind_next = RESP_READ;
        rdata_next = {regs_reg[{addr[7:1], 1'b1}], regs_reg[{addr[7:1], 1'b0}]};
      end else if (op == OP_WR_CMD) begin
        allowed = !locked || (addr == LOCK_RESET_ADDR);
        if (allowed) begin
          kind_next = RESP_WRITE;
          done_next = 1'b1;
          if (!read_only_map_i[addr]) begin
            if (locked) begin
              regs_next[addr] = (regs_reg[addr] & ~RESET_FIELD_MASK) | (data & RESET_FIELD_MASK);
            end else begin
              regs_next[addr] = data;
            end
          end
          rdata_next = {regs_next[{addr[7:1], 1'b1}], regs_next[{addr[7:1], 1'b0}]};
        end
      end else if (op[0]) begin
        kind_next = RESP_SAMPLE;
        chan_next = op[3:1];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < 256; i++) begin
        regs_reg[i] <= 8'h00;
      end
      sclk_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
      rx_reg <= 32'h00000000;
      tx_reg <= 32'h00000000;
      nbits_reg <= 6'h00;
      crc_reg <= CRC_SEED;
      kind_reg <= RESP_ERROR;
      chan_reg <= 3'h0;
      rdata_reg <= 16'h0000;
      miso_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      done_reg <= 1'b0;
      crcerr_reg <= 1'b0;
    end else begin
      regs_reg <= regs_next;
      sclk_d_reg <= sclk_d_next;
      cs_d_reg <= cs_d_next;
      rx_reg <= rx_next;
      tx_reg <= tx_next;
      nbits_reg <= nbits_next;
      crc_reg <= crc_next;
      kind_reg <= kind_next;
      chan_reg <= chan_next;
      rdata_reg <= rdata_next;
      miso_reg <= miso_next;
      oe_n_reg <= oe_n_next;
      done_reg <= done_next;
      crcerr_reg <= crcerr_next;
    end
  end

  // lock and reset field live in the lock-and-reset register, bit 7 is the lock
  assign config_lock_bit_o = regs_reg[LOCK_RESET_ADDR][7];
  assign reset_request_o = regs_reg[LOCK_RESET_ADDR][RESET_FIELD_LSB +: 2];
  assign miso_o = miso_reg;
  assign miso_oe_n_o = oe_n_reg;
  assign write_done_o = done_reg;
  assign crc_error_o = crcerr_reg;
endmodule : spi_cmd_core

// >>> bench/spi_cmd_core_asserts.sv
// port checker for spi_cmd_core
// bound to every core instance, sees only its ports
`timescale 1ns/1ps
module spi_cmd_core_asserts (
  // watched ports
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic miso_o,
  input wire logic miso_oe_n_o,
  input wire logic config_lock_bit_o,
  input wire logic [1:0] reset_request_o,
  input wire logic write_done_o,
  input wire logic crc_error_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // long stretches outlast the pin synchroniser delay
  sequence s_idle;
    cs_n_i [*8];
  endsequence
  sequence s_busy;
    !cs_n_i [*8];
  endsequence
  property p_oe_off;
    s_idle |-> miso_oe_n_o;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("miso driven while idle");
  property p_oe_on;
    s_busy |-> !miso_oe_n_o;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("miso not driven in frame");
  property p_calm;
    s_busy |-> $stable(config_lock_bit_o) && $stable(reset_request_o);
  endproperty
  a_calm: assert property (p_calm) else $error("register moved in frame");
  property p_sticky;
    config_lock_bit_o |=> config_lock_bit_o;
  endproperty
  a_sticky: assert property (p_sticky) else $error("lock cleared");
  property p_done_pulse;
    write_done_o |=> !write_done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  property p_crc_pulse;
    crc_error_o |-> !write_done_o ##1 (!write_done_o && !crc_error_o);
  endproperty
  a_crc_pulse: assert property (p_crc_pulse) else $error("write on bad crc");
  property p_done_idle;
    write_done_o |-> cs_n_i && $past(cs_n_i);
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("write inside frame");
  property p_miso_hold;
    (!cs_n_i && sclk_i) [*4] |-> $stable(miso_o);
  endproperty
  a_miso_hold: assert property (p_miso_hold) else $error("miso moved on high sclk");
endmodule : spi_cmd_core_asserts
bind spi_cmd_core spi_cmd_core_asserts chk (.*);

// >>> bench/spi_host_model.sv
// spi host model, mode 0, one 32-bit frame per call
// assumes the device shifts msb first on miso
`timescale 1ns/1ps
module spi_host_model (
  // spi pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // sclk stands low between frames; miso read late in the high phase
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    cs_n_o = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      mosi_o = tx[i];
      #24 sclk_o = 1'b1;
      #23 rx[i] = miso_i;
      #1 sclk_o = 1'b0;
    end
    #24 cs_n_o = 1'b1;
    mosi_o = ~mosi_o; // released line must not look valid
    #96;
  endtask : xfer
endmodule : spi_host_model

// >>> bench/spi_cmd_core_tb.sv
// testbench for spi_cmd_core, frames sent through the host model
// assumes each answer arrives in the frame after its command
`timescale 1ns/1ps
module spi_cmd_core_tb;
  import spi_cmd_pkg::*;
  logic ref_clk_i = 0, reset_n_i = 0, vfy = 0;
  logic sclk, cs_n, mosi, miso, oe_n, lock, done, crc_err;
  logic [95:0] meas = 96'h777666555444333222111000; // channel n holds 12'hnnn
  int n_done = 0, n_crc = 0;
  // one skew for every stimulus change, clear of both clock edges
  localparam realtime DLY = 1.25;
  logic [1:0] rst_req;
  logic [255:0] ro_map = '0;
  logic [31:0] rx;
  int fail_count = 0, samples_checked = 0, cyc = 0;
  localparam logic [1:0] HB = 2'h1;
  localparam logic [1:0] SF = 2'h2;
  localparam logic [23:0] ERR = {4'h0, 2'h3, 16'h0, SF};
  always #2.5 ref_clk_i = ~ref_clk_i;
  // released miso shows the inverse: no pull on the line, so stale bits get caught
  wire miso_line = oe_n ? ~miso : miso;
  spi_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_line));
  spi_cmd_core uut (.ref_clk_i, .reset_n_i, .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
    .miso_oe_n_o(oe_n), .basic_health_bits_i(HB), .detail_fault_bits_i(SF), .miso_verify_err_i(vfy),
    .measurement_value_i(meas), .read_only_map_i(ro_map), .config_lock_bit_o(lock),
    .reset_request_o(rst_req), .write_done_o(done), .crc_error_o(crc_err));
  // own serial crc, msb first
  function automatic logic [7:0] crc8(input logic [23:0] h);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? 8'h2f : 8'h00);
    return c;
  endfunction : crc8
  function automatic logic [23:0] ans(input logic [3:0] op, input logic [7:0] hi, input logic [7:0] lo);
    return {op, HB, 2'h0, hi, lo};
  endfunction : ans
  task automatic chk_frame(input logic [31:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== {exp, crc8(exp)}) begin
      fail_count++;
      $display("CHECK FAILED at %0t: frame %h", $time, got);
    end
  endtask : chk_frame
  task automatic chk_bits(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: bits %h", $time, got);
    end
  endtask : chk_bits
  // one frame: header plus crc, optionally corrupted
  task automatic fr(input logic [3:0] op, input logic [7:0] a, input logic [7:0] d, input logic bad = 0);
    @(posedge ref_clk_i);
    #DLY host.xfer({op, 4'h0, a, d, crc8({op, 4'h0, a, d}) ^ {7'h0, bad}}, rx);
  endtask : fr
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  // count event pulses between edges, where they are settled
  always @(negedge ref_clk_i) begin
    if (done === 1'b1) n_done++;
    if (crc_err === 1'b1) n_crc++;
  end
  // hang guard, frames take about 330 cycles each
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk_i);
    #DLY reset_n_i = 1'b1;
    repeat (8) @(posedge ref_clk_i);
    fr(OP_WR_CMD, 8'h04, 8'h5a);
    fr(OP_WR_CMD, 8'h05, 8'ha5);
    chk_frame(rx, ans(4'h4, 8'h00, 8'h5a));
    fr(OP_RD_CMD, 8'h04, 8'h00);
    chk_frame(rx, ans(4'h4, 8'ha5, 8'h5a));
    fr(OP_WR_CMD, 8'h04, 8'hff, 1'b1);
    chk_frame(rx, ans(4'h6, 8'ha5, 8'h5a));
    fr(OP_RD_CMD, 8'h04, 8'h00);
    chk_frame(rx, ERR);
    @(posedge ref_clk_i) #DLY ro_map[6] = 1'b1;
    fr(OP_WR_CMD, 8'h06, 8'h33);
    chk_frame(rx, ans(4'h6, 8'ha5, 8'h5a));
    @(posedge ref_clk_i) #DLY vfy = 1'b1;
    fr(OP_WR_CMD, 8'h04, 8'h77);
    chk_frame(rx, ans(4'h4, 8'h00, 8'h00));
    @(posedge ref_clk_i) #DLY vfy = 1'b0;
    $display("test access done");
    fr(OP_WR_CMD, 8'h0e, 8'h81);
    chk_frame(rx, ERR);
    chk_bits({5'h0, lock, rst_req}, 8'h05);
    fr(OP_WR_CMD, 8'h04, 8'h11);
    chk_frame(rx, ans(4'h4, 8'h00, 8'h81));
    fr(OP_WR_CMD, 8'h0e, 8'h02);
    chk_frame(rx, ERR);
    fr(OP_RD_CMD, 8'h04, 8'h00);
    chk_frame(rx, ans(4'h4, 8'h00, 8'h82));
    chk_bits({5'h0, lock, rst_req}, 8'h06);
    fr(4'h5, 8'h00, 8'h00);
    chk_frame(rx, ans(4'h6, 8'ha5, 8'h5a));
    // sample source moves in mid-frame: the answer keeps the value from frame start
    fork
      fr(4'hb, 8'h00, 8'h00);
      begin
        repeat (40) @(posedge ref_clk_i);
        #DLY meas = ~meas;
      end
    join
    chk_frame(rx, {3'h2, 1'b1, HB, 12'h222, 4'h0, SF});
    chk_bits({rx[27:26], 6'h0}, {HB, 6'h0});
    fr(OP_RD_CMD, 8'h04, 8'h00);
    chk_frame(rx, {3'h5, 1'b1, HB, 12'haaa, 4'h0, SF});
    chk_bits(n_done[7:0], 8'h05);
    chk_bits(n_crc[7:0], 8'h01);
    $display("test lock and sample done");
    end_sim();
  end
endmodule : spi_cmd_core_tb
